/* hdl/fwps_core.sv */
// Serial-flash front end: instruction decode, status word, write protection.
// Assumes the array core reports completion on array_done in the core clock domain.
`default_nettype none

module fwps_core
    import fwps_pkg::*;
#(
    parameter int PUW_US = 10000
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire fwps_pins_s pins,
    input wire logic array_done,
    output logic spi_do,
    output logic spi_do_oe_b,
    output fwps_cmd_s array_cmd,
    output fwps_byte_s prog_data,
    output logic [15:0] status_word
);

    localparam int PUW_CYCLES = (PUW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic region_hit(input logic [23:0] a, input logic [2:0] bp,
                                        input logic tb, input logic sec, input logic cmp);
        logic in_reg;
        logic [8:0] unit;
        logic [8:0] n;
        logic [8:0] umax;
        in_reg = 1'b0;
        unit = sec ? a[ARRAY_AW-1:SECTOR_LSB] : {4'h0, a[ARRAY_AW-1:BLOCK_LSB]};
        umax = sec ? SECTOR_MAX : BLOCK_MAX;
        n = 9'h001 << (bp - 3'h1);
        if (bp == 3'h0)
        begin
            in_reg = 1'b0; // see R10
        end
        else if (bp[2:1] == 2'b11)
        begin
            in_reg = 1'b1;
        end
        else
        begin
            if (sec && bp[2])
            begin
                n = SEC_32K_UNITS; // see R12
            end
            in_reg = tb ? (unit < n) : (unit > (umax - n)); // see R11
        end
        return in_reg ^ cmp; // see R13
    endfunction

    function automatic logic is_write_op(input logic [7:0] op);
        return op == OP_WREN || op == OP_PP || op == OP_SE || op == OP_BE ||
               op == OP_CE || op == OP_WRSR;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link edges

    fwps_pins_s pins_s1;
    fwps_pins_s pins_s2;
    fwps_pins_s pins_s3;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            pins_s1 <= '{cs_b: 1'b1, sclk: 1'b0, di: 1'b0, wp_b: 1'b0};
            pins_s2 <= '{cs_b: 1'b1, sclk: 1'b0, di: 1'b0, wp_b: 1'b0};
            pins_s3 <= '{cs_b: 1'b1, sclk: 1'b0, di: 1'b0, wp_b: 1'b0};
        end
        else
        begin
            pins_s1 <= pins;
            pins_s2 <= pins_s1;
            pins_s3 <= pins_s2;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    assign cs_fall = pins_s3.cs_b && !pins_s2.cs_b;
    assign cs_rise = !pins_s3.cs_b && pins_s2.cs_b;
    assign sclk_rise = !pins_s2.cs_b && !pins_s3.sclk && pins_s2.sclk;
    assign sclk_fall = !pins_s2.cs_b && pins_s3.sclk && !pins_s2.sclk;

    ////////////////////////////////////////////////////////////////////////////
    // Status fields and power-up delay

    logic busy;
    logic write_enable_latch;
    logic [2:0] region_size;
    logic top_bottom_select;
    logic small_unit_select;
    logic status_lock_mode_low;
    logic status_lock_mode_high;
    logic quad_io_enable;
    logic [2:0] security_lock;
    logic protect_complement;
    logic paused_op_flag;
    logic powered_down;
    logic puw_done;
    logic [$clog2(PUW_CYCLES+1)-1:0] puw_cnt;

    assign status_word = {paused_op_flag, protect_complement, security_lock, 1'b0,
                          quad_io_enable, status_lock_mode_high, status_lock_mode_low,
                          small_unit_select, top_bottom_select, region_size,
                          write_enable_latch, busy};

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            puw_cnt <= '0; // see R01
            puw_done <= 1'b0;
        end
        else if (!puw_done)
        begin
            puw_cnt <= puw_cnt + 1'b1;
            puw_done <= (puw_cnt == ($bits(puw_cnt))'(PUW_CYCLES - 1)); // see R02
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder

    fwps_phase_e phase;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shift_in;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] sr_lo;
    logic [7:0] sr_hi;
    logic [7:0] in_byte;
    logic byte_done;
    logic op_allowed;
    logic pp_ok;

    assign in_byte = {shift_in[6:0], pins_s2.di};
    assign byte_done = sclk_rise && (bit_cnt == 3'h7);

    always_comb
    begin
        op_allowed = 1'b1;
        if (powered_down)
        begin
            op_allowed = (in_byte == OP_RPD); // see R09
        end
        else if (busy)
        begin
            op_allowed = in_byte == OP_RDSR1 || in_byte == OP_RDSR2 ||
                         in_byte == OP_SUSPEND; // see R08
        end
        else if (!puw_done && is_write_op(in_byte))
        begin
            op_allowed = 1'b0; // see R02
        end
    end

    assign pp_ok = write_enable_latch && !busy && !paused_op_flag &&
                   !region_hit(addr, region_size, top_bottom_select, small_unit_select,
                               protect_complement);

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            phase <= FWPS_IDLE; // see R01
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            sr_lo <= 8'h00;
            sr_hi <= 8'h00;
            prog_data <= '0;
        end
        else
        begin
            prog_data.valid <= 1'b0;
            if (cs_rise)
            begin
                phase <= FWPS_IDLE;
            end
            else if (cs_fall)
            begin
                phase <= FWPS_OPCODE;
                bit_cnt <= 3'h0;
                byte_cnt <= 3'h0;
            end
            else if (sclk_rise && phase != FWPS_IDLE && phase != FWPS_IGNORE)
            begin
                shift_in <= in_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done)
                begin
                    if (byte_cnt != 3'h7)
                    begin
                        byte_cnt <= byte_cnt + 3'h1;
                    end
                    if (phase == FWPS_OPCODE)
                    begin
                        opcode <= in_byte;
                        phase <= op_allowed ? FWPS_BODY : FWPS_IGNORE;
                    end
                    else if (byte_cnt < BYTES_ADDR_DONE)
                    begin
                        addr <= {addr[15:0], in_byte};
                    end
                    else if (opcode == OP_PP && pp_ok)
                    begin
                        prog_data.valid <= 1'b1;
                        prog_data.data <= in_byte;
                    end
                    if (byte_cnt == 3'h1)
                    begin
                        sr_lo <= in_byte;
                    end
                    if (byte_cnt == 3'h2)
                    begin
                        sr_hi <= in_byte;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status read shifter

    logic [7:0] out_shift;
    logic load_pending;
    logic is_read;

    assign is_read = phase == FWPS_BODY && (opcode == OP_RDSR1 || opcode == OP_RDSR2);
    assign spi_do = out_shift[7];
    assign spi_do_oe_b = !(is_read && !pins_s2.cs_b);

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            out_shift <= 8'h00;
            load_pending <= 1'b0;
        end
        else if (cs_fall)
        begin
            load_pending <= 1'b0;
        end
        else if (byte_done && (phase == FWPS_OPCODE || is_read))
        begin
            load_pending <= 1'b1;
        end
        else if (sclk_fall)
        begin
            load_pending <= 1'b0;
            if (load_pending)
            begin
                out_shift <= (opcode == OP_RDSR2) ? status_word[15:8] : status_word[7:0];
            end
            else
            begin
                out_shift <= {out_shift[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution at frame end

    logic frame_end;
    logic status_ok;
    logic [23:0] range_hi;
    logic range_hit;
    logic [1:0] sreg_sel;
    logic sreg_locked;
    fwps_kind_e exec_kind;

    assign frame_end = cs_rise && phase == FWPS_BODY;
    assign sreg_sel = addr[SECREG_SEL_LSB+1:SECREG_SEL_LSB];
    assign sreg_locked = (sreg_sel == 2'h0) || security_lock[sreg_sel - 2'h1]; // see R21
    assign range_hi = addr | ((opcode == OP_BE) ? BLOCK_SPAN : SECTOR_SPAN);
    assign range_hit = region_hit(addr, region_size, top_bottom_select, small_unit_select,
                                  protect_complement) ||
                       region_hit(range_hi, region_size, top_bottom_select,
                                  small_unit_select, protect_complement);

    always_comb
    begin
        case ({status_lock_mode_high, status_lock_mode_low}) // see R14
            2'b00: status_ok = write_enable_latch; // see R15
            2'b01: status_ok = write_enable_latch &&
                               (quad_io_enable || pins_s2.wp_b); // see R16 see R19 see R22
            default: status_ok = 1'b0; // see R17 see R18
        endcase
    end

    always_comb
    begin
        exec_kind = FWPS_K_NONE;
        if (frame_end && !busy && !paused_op_flag && write_enable_latch) // see R04
        begin
            if (opcode == OP_PP && byte_cnt >= BYTES_PP_MIN && pp_ok)
            begin
                exec_kind = FWPS_K_PROGRAM;
            end
            else if (opcode == OP_SE && byte_cnt >= BYTES_ADDR_DONE && !range_hit)
            begin
                exec_kind = FWPS_K_SECTOR_ERASE; // see R23
            end
            else if (opcode == OP_BE && byte_cnt >= BYTES_ADDR_DONE && !range_hit)
            begin
                exec_kind = FWPS_K_BLOCK_ERASE;
            end
            else if (opcode == OP_CE && ((region_size == 3'h0 && !protect_complement) ||
                     (region_size[2:1] == 2'b11 && protect_complement)))
            begin
                exec_kind = FWPS_K_CHIP_ERASE;
            end
            else if (opcode == OP_SRERASE && byte_cnt >= BYTES_ADDR_DONE && !sreg_locked)
            begin
                exec_kind = FWPS_K_SECREG_ERASE;
            end
            else if (opcode == OP_SRPROG && byte_cnt >= BYTES_PP_MIN && !sreg_locked)
            begin
                exec_kind = FWPS_K_SECREG_PROG;
            end
            else if (opcode == OP_WRSR && byte_cnt >= 3'h2 && status_ok)
            begin
                exec_kind = FWPS_K_STATUS_WRITE;
            end
        end
        else if (frame_end && opcode == OP_SUSPEND && busy &&
                 array_cmd.kind != FWPS_K_STATUS_WRITE)
        begin
            exec_kind = FWPS_K_SUSPEND;
        end
        else if (frame_end && opcode == OP_RESUME && paused_op_flag)
        begin
            exec_kind = FWPS_K_RESUME;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            array_cmd <= '{valid: 1'b0, kind: FWPS_K_NONE, addr: 24'h000000};
        end
        else
        begin
            array_cmd.valid <= exec_kind != FWPS_K_NONE;
            if (exec_kind != FWPS_K_NONE && exec_kind != FWPS_K_SUSPEND &&
                exec_kind != FWPS_K_RESUME)
            begin
                array_cmd.kind <= exec_kind;
                array_cmd.addr <= addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word update

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            {paused_op_flag, protect_complement, security_lock} <= STATUS_RESET[15:11];
            {quad_io_enable, status_lock_mode_high, status_lock_mode_low} <= STATUS_RESET[9:7];
            {small_unit_select, top_bottom_select, region_size} <= STATUS_RESET[6:2];
            write_enable_latch <= STATUS_RESET[ST_WEL]; // see R03 see R17
            busy <= STATUS_RESET[ST_BUSY];
            powered_down <= 1'b0;
        end
        else
        begin
            if (array_done && busy)
            begin
                busy <= 1'b0; // see R07
            end
            if (frame_end && opcode == OP_WREN)
            begin
                write_enable_latch <= 1'b1; // see R05
            end
            if (frame_end && opcode == OP_WRDI)
            begin
                write_enable_latch <= 1'b0; // see R06
            end
            if (frame_end && opcode == OP_PD)
            begin
                powered_down <= 1'b1;
            end
            if (frame_end && opcode == OP_RPD)
            begin
                powered_down <= 1'b0;
            end
            case (exec_kind)
                FWPS_K_NONE: ;
                FWPS_K_SUSPEND:
                begin
                    paused_op_flag <= 1'b1; // see R20
                    busy <= 1'b0;
                end
                FWPS_K_RESUME:
                begin
                    paused_op_flag <= 1'b0; // see R20
                    busy <= 1'b1;
                end
                default:
                begin
                    busy <= 1'b1; // see R07
                    write_enable_latch <= 1'b0; // see R06
                    if (exec_kind == FWPS_K_STATUS_WRITE)
                    begin
                        {status_lock_mode_low, small_unit_select, top_bottom_select} <=
                            sr_lo[ST_LOCK_LO:ST_TB];
                        region_size <= sr_lo[ST_BP_LSB+2:ST_BP_LSB]; // see R10
                        if (byte_cnt >= BYTES_WRSR_FULL)
                        begin
                            status_lock_mode_high <= sr_hi[ST_LOCK_HI-8];
                            quad_io_enable <= sr_hi[ST_QE-8]; // see R22
                            security_lock <= security_lock | sr_hi[ST_LB_LSB-6:ST_LB_LSB-8];
                            protect_complement <= sr_hi[ST_CMP-8]; // see R13
                        end
                    end
                end
            endcase
        end
    end

endmodule // fwps_core

`default_nettype wire

/* hdl/fwps_pkg.sv */
// Constants, types and opcodes for the flash write-protect and status-word block.
// Assumes one core clock at 10 MHz; all pin inputs arrive asynchronously.
//
// How it works
// R01: Supply-low reset blocks all decoding
// R02: Power-up delay blocks write-type instructions
// R03: Power-up leaves write enable latch clear
// R04: Writes refused unless write enable latch set
// R05: Write enable instruction sets latch at S1
// R06: Listed instructions clear the write enable latch
// R07: Busy at S0 high through every operation
// R08: Busy ignores all but status reads, suspend
// R09: Power-down ignores all but release
// R10: Region size bits S4-S2 pick protection
// R11: Top/bottom select: top at 0, bottom 1
// R12: Small unit: 4KB sectors or 64KB blocks
// R13: Complement bit S14 inverts the protection
// R14: Lock mode bits at S8 and S7
// R15: Lock 00: pin ignored, latch suffices
// R16: Lock 01: pin low refuses status writes
// R17: Lock 10: refuse until power cycle
// R18: Lock 11: status writes refused until power cycle
// R19: Pin counts only outside quad mode
// R20: Suspend sets S15, resume clears it
// R21: Security lock bits S13-S11 only set
// R22: Quad enable S9 turns pins into data; the code only uses it to ignore wp_b for status writes in lock 01
// R23: Refused operations change nothing, no busy
// R24: Host polls busy before next write
`default_nettype none

package fwps_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // Instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE = 8'hD8;
    localparam logic [7:0] OP_CE = 8'hC7;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_PD = 8'hB9;
    localparam logic [7:0] OP_RPD = 8'hAB;
    localparam logic [7:0] OP_SRERASE = 8'h44;
    localparam logic [7:0] OP_SRPROG = 8'h42;

    // Array geometry
    localparam int ARRAY_AW = 21;
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    localparam logic [8:0] SECTOR_MAX = 9'h1FF;
    localparam logic [8:0] BLOCK_MAX = 9'h01F;
    localparam logic [8:0] SEC_32K_UNITS = 9'h008;
    localparam logic [23:0] SECTOR_SPAN = 24'h000FFF;
    localparam logic [23:0] BLOCK_SPAN = 24'h00FFFF;
    localparam int SECREG_SEL_LSB = 12;

    // Status word bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LSB = 2;
    localparam int ST_TB = 5;
    localparam int ST_SEC = 6;
    localparam int ST_LOCK_LO = 7;
    localparam int ST_LOCK_HI = 8;
    localparam int ST_QE = 9;
    localparam int ST_LB_LSB = 11;
    localparam int ST_CMP = 14;
    localparam int ST_SUS = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Frame byte counts
    localparam logic [2:0] BYTES_ADDR_DONE = 3'h4;
    localparam logic [2:0] BYTES_PP_MIN = 3'h5;
    localparam logic [2:0] BYTES_WRSR_FULL = 3'h3;

    typedef enum logic [1:0] {
        FWPS_IDLE = 2'b00,
        FWPS_OPCODE = 2'b01,
        FWPS_BODY = 2'b11,
        FWPS_IGNORE = 2'b10
    } fwps_phase_e;

    typedef enum logic [3:0] {
        FWPS_K_NONE = 4'h0,
        FWPS_K_PROGRAM = 4'h1,
        FWPS_K_SECTOR_ERASE = 4'h2,
        FWPS_K_BLOCK_ERASE = 4'h3,
        FWPS_K_CHIP_ERASE = 4'h4,
        FWPS_K_SECREG_ERASE = 4'h5,
        FWPS_K_SECREG_PROG = 4'h6,
        FWPS_K_STATUS_WRITE = 4'h7,
        FWPS_K_SUSPEND = 4'h8,
        FWPS_K_RESUME = 4'h9
    } fwps_kind_e;

    typedef struct packed {
        logic cs_b;
        logic sclk;
        logic di;
        logic wp_b;
    } fwps_pins_s;

    typedef struct packed {
        logic valid;
        fwps_kind_e kind;
        logic [23:0] addr;
    } fwps_cmd_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fwps_byte_s;

endpackage

`default_nettype wire

/* sim/fwps_core_monitor.sv */
// Port checker for fwps_core.
// Assumes a bind onto fwps_core and one core clock domain.
`default_nettype none

module fwps_core_monitor
    import fwps_pkg::*;
#(
    parameter int PUW_US = 10000
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire fwps_pins_s pins,
    input wire logic array_done,
    input wire logic spi_do,
    input wire logic spi_do_oe_b,
    input wire fwps_cmd_s array_cmd,
    input wire fwps_byte_s prog_data,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge core_clk);
    endclocking
    ////////////////////////////////////////
    property p_rst_clear;
        !rst_b |=> status_word == 16'h0000;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("status not cleared by reset");
    property p_cmd_busy;
        disable iff (!rst_b) array_cmd.valid |-> status_word[0] != status_word[15];
    endproperty
    a_cmd_busy: assert property (p_cmd_busy)
        else $error("start without busy");
    property p_cmd_wel;
        disable iff (!rst_b)
        array_cmd.valid && status_word[0] && !$past(status_word[15]) |-> !status_word[1];
    endproperty
    a_cmd_wel: assert property (p_cmd_wel)
        else $error("latch kept after start");
    property p_busy_end;
        disable iff (!rst_b) $fell(status_word[0]) |-> $past(array_done) || status_word[15];
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy cleared without completion");
    property p_busy_wren;
        disable iff (!rst_b) $rose(status_word[1]) |-> !$past(status_word[0]);
    endproperty
    a_busy_wren: assert property (p_busy_wren)
        else $error("write enable accepted while busy");
    property p_busy_start;
        disable iff (!rst_b) $rose(status_word[0]) |-> array_cmd.valid;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy without start");
    property p_otp_keep;
        disable iff (!rst_b) ($past(status_word[13:11]) & ~status_word[13:11]) == 3'h0;
    endproperty
    a_otp_keep: assert property (p_otp_keep)
        else $error("security lock bit cleared");
    property p_lock_hold;
        disable iff (!rst_b) status_word[8] |=> $stable(status_word[14:2]);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("status changed under lock");
endmodule // fwps_core_monitor

bind fwps_core fwps_core_monitor #(.PUW_US(PUW_US)) i_fwps_core_monitor (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pins(pins),
    .array_done(array_done),
    .spi_do(spi_do),
    .spi_do_oe_b(spi_do_oe_b),
    .array_cmd(array_cmd),
    .prog_data(prog_data),
    .status_word(status_word)
);

`default_nettype wire

/* sim/fwps_core_tb.sv */
// Self-checking bench for fwps_core.
// Assumes fwps_host drives the pins and the monitor is bound.
`default_nettype none

module fwps_core_tb
    import fwps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PUW = 20;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic array_done = 1'b0;
    logic wp_b = 1'b1;
    fwps_pins_s pins;
    logic spi_do;
    logic spi_do_oe_b;
    fwps_cmd_s array_cmd;
    fwps_byte_s prog_data;
    logic [15:0] status_word;
    logic [15:0] exp_sw;
    logic [15:0] rnd = 16'h0010;
    logic [7:0] rd;
    logic [20:0] a;
    logic [7:0] pd;
    int n_fail = 0;
    int cmp_count = 0;
    int n_cmd = 0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (array_cmd.valid === 1'b1) n_cmd++;
    always @(posedge core_clk) if (prog_data.valid === 1'b1) pd <= prog_data.data;
    fwps_core #(.PUW_US(PUW)) i_fwps_core (.core_clk(core_clk), .rst_b(rst_b), .pins(pins),
        .array_done(array_done), .spi_do(spi_do), .spi_do_oe_b(spi_do_oe_b),
        .array_cmd(array_cmd), .prog_data(prog_data), .status_word(status_word));
    fwps_host i_fwps_host (.core_clk(core_clk), .wp_b(wp_b), .spi_do(spi_do), .pins(pins));
    ////////////////////////////////////////
    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic prot(input logic [15:0] s, input logic [20:0] ad);
        int bp;
        int sz;
        logic p;
        bp = int'(s[4:2]);
        sz = s[6] ? (4096 << (bp > 4 ? 3 : bp - 1)) : (65536 << (bp - 1));
        p = bp == 0 ? 1'b0 : bp >= 6 ? 1'b1 : s[5] ? int'(ad) < sz : int'(ad) >= 2097152 - sz;
        return p ^ s[14];
    endfunction
    task automatic fr(input logic [31:0] d, input int nb);
        i_fwps_host.xfer(d, nb, rd);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic done_pulse;
        array_done <= 1'b1;
        @(posedge core_clk);
        array_done <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // Write enable, then the instruction; expect a start or a refusal
    task automatic op(input logic [31:0] d, input int nb, input logic go);
        int c;
        fr(32'h06000000, 1);
        c = n_cmd;
        fr(d, nb);
        chk("started", {15'h0000, go}, 16'(n_cmd - c));
        if (go)
        begin
            chk("busy_wel", 16'h0001, {14'h0000, status_word[1:0]});
            if (d[31:24] == 8'h20)
                chk("se", {FWPS_K_SECTOR_ERASE, d[20:9]},
                    {array_cmd.kind, array_cmd.addr[20:9]});
            done_pulse();
            fr(32'h05000000, 2);
            chk("poll", {8'h00, exp_sw[7:0]}, {8'h00, rd});
        end
        chk("busy_end", 16'h0000, {15'h0000, status_word[0]});
        chk("status", exp_sw, status_word & 16'hFFFC);
    endtask
    task automatic power_cycle;
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        fr(32'h06000000, 1);
        chk("puw_wel", 16'h0000, status_word);
        repeat (200) @(posedge core_clk);
        exp_sw = 16'h0000;
        chk("por", exp_sw, status_word);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
    initial
    begin
        power_cycle();
        fr(32'h01FC0000, 2);
        chk("no_wel", exp_sw, status_word);
        fr(32'h06000000, 1);
        chk("wren", 16'h0002, status_word);
        fr(32'h04000000, 1);
        chk("wrdi", 16'h0000, status_word);
        for (int k = 0; k < 14; k++)
        begin
            rnd = lfsr(rnd);
            exp_sw = {1'b0, rnd[14], 7'h00, rnd[6:2], 2'b00};
            op({8'h01, exp_sw[7:0], exp_sw[15:8], 8'h00}, 3, 1'b1);
            fr(32'h05000000, 2);
            chk("rd_lo", {8'h00, exp_sw[7:0]}, {8'h00, rd});
            rnd = lfsr(rnd);
            a = k == 0 ? 21'h000000 : k == 1 ? 21'h1FF000 : {rnd[8:0], 12'h000};
            op({8'h20, 3'h0, a}, 4, !prot(exp_sw, a));
        end
        exp_sw = 16'h0000;
        op(32'h01000000, 3, 1'b1);
        op(32'h20000000, 4, 1'b1);
        op(32'h02000000, 5, 1'b1);
        chk("prog", 16'h0002, {8'h00, pd});
        fr(32'h06000000, 1);
        fr(32'h20000000, 4);
        fr(32'h06000000, 1);
        chk("busy_ign", 16'h0001, status_word);
        fr(32'h05000000, 2);
        chk("busy_rd", 16'h0001, {8'h00, rd});
        chk("oe", 16'h0001, {15'h0000, spi_do_oe_b});
        fr(32'h75000000, 1);
        chk("suspend", 16'h8000, status_word);
        fr(32'h7A000000, 1);
        chk("resume", 16'h0001, status_word);
        done_pulse();
        fr(32'hB9000000, 1);
        fr(32'h06000000, 1);
        chk("pd_ign", 16'h0000, status_word);
        fr(32'hAB000000, 1);
        fr(32'h06000000, 1);
        chk("pd_rel", 16'h0002, status_word);
        exp_sw = 16'h3880;
        op(32'h01803800, 3, 1'b1);
        fr(32'h35000000, 2);
        chk("rd_hi", 16'h0038, {8'h00, rd});
        op(32'h44001000, 4, 1'b0);
        wp_b <= 1'b0;
        op(32'h01000000, 3, 1'b0);
        wp_b <= 1'b1;
        exp_sw = 16'h3A80;
        op(32'h01803A00, 3, 1'b1);
        wp_b <= 1'b0;
        exp_sw = 16'h3980;
        op(32'h01803900, 3, 1'b1);
        op(32'h01000000, 3, 1'b0);
        power_cycle();
        exp_sw = 16'h0100;
        op(32'h01000100, 3, 1'b1);
        op(32'h01040000, 3, 1'b0);
        power_cycle();
        final_report();
    end
endmodule // fwps_core_tb

`default_nettype wire

/* sim/fwps_host.sv */
// Serial bus host model: mode 0 frames, MSB first, 800 ns bit period.
// Assumes a 100 ns core clock; wp_b level comes from the bench.
`default_nettype none

module fwps_host
    import fwps_pkg::*;
(
    input wire logic core_clk,
    input wire logic wp_b,
    input wire logic spi_do,
    output var fwps_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = '{cs_b: 1'b1, sclk: 1'b0, di: 1'b0, wp_b: 1'b1};
    always @(posedge core_clk) pins.wp_b <= wp_b;
    ////////////////////////////////////////
    // One instruction per frame; clock idles low between frames
    task automatic xfer(input logic [31:0] d, input int nb, output logic [7:0] rd);
        @(posedge core_clk);
        pins.cs_b <= 1'b0;
        for (int i = 0; i < nb * 8; i++)
        begin
            pins.di <= d[31 - (i % 32)];
            repeat (4) @(posedge core_clk);
            pins.sclk <= 1'b1;
            rd = {rd[6:0], spi_do};
            repeat (4) @(posedge core_clk);
            pins.sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        pins.cs_b <= 1'b1;
        pins.di <= ~pins.di;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // fwps_host

`default_nettype wire
